// *** src/arc_pkg.sv ***
// constants, types and register map of the adc result computation unit
// assumes an ahb-lite master, word accesses, and a converter core that
// pulses conv_done with a right-justified 16-bit result
//
// Notes on behaviour
// - add each new result into 16-bit accumulator
// - sum above 65535 sets overflow flag
// - each added sample increments sample count up to 255
// - clear command zeroes accumulator, overflow, count
// - rc clock: clearing takes five rc ticks
// - accumulator right-shifted by shift amount
// - low-pass mode: shift sets filter coefficient
// - basic mode: no accumulation, threshold still runs
// - accumulate mode: shifted accumulator into filtered register
// - accumulate mode: threshold test every sample
// - average mode: threshold only once count reaches target
// - burst mode: retrigger until count reaches target
// - low-pass mode: filter, test at target count
// - results latched at end of conversion
// - error codes 0..3: differences, reserved
// - error codes 4..7: prev-filt, filt-setpt, raw, filt
// - compare error against both thresholds, set flags
// - threshold mode picks interrupt condition
// - error and thresholds compared as signed
// - overflow always raises threshold interrupt
// - double sampling: error every second sample
// - continuous mode re-sets go after each update
// - double sample: first conversion sets flag only
// - continuous retrigger stops on interrupt or go cleared; burst retrigger ignores interrupt
`default_nettype none

package arc_pkg;

  localparam int         ADDR_W      = 8;
  // --------------------------------------------------------------
  // register byte offsets
  // --------------------------------------------------------------
  localparam logic [7:0] A_CTRL      = 8'h00;
  localparam logic [7:0] A_COMP      = 8'h04;
  localparam logic [7:0] A_STAT      = 8'h08;
  localparam logic [7:0] A_RPT       = 8'h0C;
  localparam logic [7:0] A_CNT       = 8'h10;
  localparam logic [7:0] A_STPT      = 8'h14;
  localparam logic [7:0] A_LTH       = 8'h18;
  localparam logic [7:0] A_UTH       = 8'h1C;
  localparam logic [7:0] A_RES       = 8'h20;
  localparam logic [7:0] A_PREV      = 8'h24;
  localparam logic [7:0] A_ACC       = 8'h28;
  localparam logic [7:0] A_FLTR      = 8'h2C;
  localparam logic [7:0] A_ERR       = 8'h30;
  // --------------------------------------------------------------
  // status bits, write one to clear the two event flags
  // --------------------------------------------------------------
  localparam int         ST_AOV      = 0;
  localparam int         ST_UTHR     = 1;
  localparam int         ST_LTHR     = 2;
  localparam int         ST_MATH     = 3;
  localparam int         ST_TIF      = 4;
  localparam int         CTRL_W      = 5;
  localparam int         COMP_W      = 14;
  localparam logic [7:0] CNT_MAX     = 8'hFF;
  localparam logic [2:0] CLR_RC_TICKS = 3'h5;

  typedef enum logic [2:0] {
    MD_BASIC = 3'b000,
    MD_ACC   = 3'b001,
    MD_AVG   = 3'b010,
    MD_BURST = 3'b011,
    MD_LPF   = 3'b100
  } arc_mode_t;

  typedef enum logic [2:0] {
    CALC_RES_PREV  = 3'b000,
    CALC_RES_STPT  = 3'b001,
    CALC_RES_FLT   = 3'b010,
    CALC_RSVD      = 3'b011,
    CALC_PREV_FLT  = 3'b100,
    CALC_FLT_STPT  = 3'b101,
    CALC_RAW       = 3'b110,
    CALC_FLT       = 3'b111
  } arc_calc_t;

  typedef enum logic [2:0] {
    TM_NEVER   = 3'b000,
    TM_BELOW   = 3'b001,
    TM_AT_ABV  = 3'b010,
    TM_INSIDE  = 3'b011,
    TM_OUTSIDE = 3'b100,
    TM_AT_BLW  = 3'b101,
    TM_ABOVE   = 3'b110,
    TM_ALWAYS  = 3'b111
  } arc_tmode_t;

  typedef enum logic {
    CLR_IDLE = 1'b0,
    CLR_WAIT = 1'b1
  } arc_clr_state_t;

  // layout of the control word at A_CTRL, bit 4 down to bit 0
  typedef struct packed {
    logic prev_source_select;
    logic double_sample_enable;
    logic clock_src_rc;
    logic continuous_enable;
    logic conversion_go;
  } arc_ctrl_t;

  // layout of the computation word at A_COMP, bit 13 down to bit 0
  typedef struct packed {
    logic       stop_on_interrupt;
    logic [2:0] threshold_mode_sel;
    logic [2:0] error_calc_sel;
    logic       acc_clear_cmd;
    logic [2:0] shift_amount;
    logic [2:0] compute_mode_sel;
  } arc_comp_t;

endpackage : arc_pkg

`default_nettype wire

// *** src/arc_unit.sv ***
// adc result computation unit: accumulator, filter, error and threshold
// assumes one converter core handing results with a one-cycle conv_done,
// and rc_tick as a one-cycle enable at the rc oscillator rate
`default_nettype none

module arc_unit (
  input  wire logic                    ref_clk,
  input  wire logic                    rst,
  input  wire logic                    hsel,
  input  wire logic [31:0]             haddr,
  input  wire logic [1:0]              htrans,
  input  wire logic                    hwrite,
  input  wire logic [2:0]              hsize,
  input  wire logic [31:0]             hwdata,
  input  wire logic                    hready,
  output logic                         hreadyout,
  output logic                         hresp,
  output logic [31:0]                  hrdata,
  input  wire logic                    conv_done,
  input  wire logic [15:0]             conv_result,
  input  wire logic                    ext_trigger,
  input  wire logic                    rc_tick,
  output logic                         conversion_go,
  output logic                         threshold_irq_flag
);
  import arc_pkg::*;

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  logic              wr_ph_ff;
  logic              rd_ph_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [31:0]       hrdata_ff;
  logic [31:0]       rd_mux;

  wire take = hsel && htrans[1] && hready;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wr_ph_ff <= 1'b0;
      rd_ph_ff <= 1'b0;
      addr_ff  <= '0;
    end else begin
      wr_ph_ff <= take && hwrite;
      rd_ph_ff <= take && !hwrite;
      if (take) begin
        addr_ff <= haddr[ADDR_W-1:0];
      end
    end
  end

  // one wait state on reads so read data always comes from a flop
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hrdata_ff <= '0;
    end else if (rd_ph_ff) begin
      hrdata_ff <= rd_mux;
    end
  end

  assign hreadyout = !rd_ph_ff;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_ff;

  wire wr_ctrl = wr_ph_ff && (addr_ff == A_CTRL);
  wire wr_comp = wr_ph_ff && (addr_ff == A_COMP);
  wire wr_stat = wr_ph_ff && (addr_ff == A_STAT);
  wire wr_rpt  = wr_ph_ff && (addr_ff == A_RPT);
  wire wr_stpt = wr_ph_ff && (addr_ff == A_STPT);
  wire wr_lth  = wr_ph_ff && (addr_ff == A_LTH);
  wire wr_uth  = wr_ph_ff && (addr_ff == A_UTH);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  arc_ctrl_t      ctrl_ff;
  arc_comp_t      comp_ff;
  arc_clr_state_t clr_st_ff;
  logic [2:0]     clr_tick_ff;
  logic [7:0]     rpt_ff;
  logic [7:0]     cnt_ff;
  logic [15:0]    stpt_ff;
  logic [15:0]    lth_ff;
  logic [15:0]    uth_ff;
  logic [15:0]    res_ff;
  logic [15:0]    prev_ff;
  logic [15:0]    s1_ff;
  logic [15:0]    acc_ff;
  logic [15:0]    fltr_ff;
  logic [15:0]    err_ff;
  logic           half_ff;
  logic           aov_ff;
  logic           uthr_ff;
  logic           lthr_ff;
  logic           math_ff;
  logic           tif_ff;

  wire arc_comp_t wcomp = arc_comp_t'(hwdata[COMP_W-1:0]);
  wire arc_ctrl_t wctrl = arc_ctrl_t'(hwdata[CTRL_W-1:0]);
  wire arc_mode_t md    = arc_mode_t'(comp_ff.compute_mode_sel);
  wire [2:0]      crs   = comp_ff.shift_amount;

  // ------------------------------------------------------------
  // accumulator clear sequencer
  // ------------------------------------------------------------
  // on the rc clock the clear only finishes after five rc ticks
  wire clr_fire = comp_ff.acc_clear_cmd &&
                  ((clr_st_ff == CLR_IDLE && !ctrl_ff.clock_src_rc) ||
                   (clr_st_ff == CLR_WAIT && rc_tick &&
                    clr_tick_ff == CLR_RC_TICKS - 3'h1));

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      clr_st_ff   <= CLR_IDLE;
      clr_tick_ff <= '0;
    end else begin
      unique case (clr_st_ff)
        CLR_IDLE: begin
          clr_tick_ff <= '0;
          if (comp_ff.acc_clear_cmd && ctrl_ff.clock_src_rc) begin
            clr_st_ff <= CLR_WAIT;
          end
        end
        CLR_WAIT: begin
          if (clr_fire || !comp_ff.acc_clear_cmd) begin
            clr_st_ff <= CLR_IDLE;
          end else if (rc_tick) begin
            clr_tick_ff <= clr_tick_ff + 3'h1;
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // sample path
  // ------------------------------------------------------------
  wire        first_conv = ctrl_ff.double_sample_enable && !half_ff;
  wire        cyc_done   = conv_done && !first_conv;
  wire        accum      = md inside {MD_ACC, MD_AVG, MD_BURST, MD_LPF};
  wire        restart    = (md == MD_AVG) && (cnt_ff >= rpt_ff);
  wire [15:0] acc_base   = restart ? '0 : acc_ff;
  wire [7:0]  cnt_base   = restart ? '0 : cnt_ff;
  // double sampling feeds the difference of the pair
  wire [16:0] samp = ctrl_ff.double_sample_enable ?
                     17'({1'b0, conv_result} - {1'b0, s1_ff}) :
                     {1'b0, conv_result};
  wire [15:0] decay    = (md == MD_LPF) ? (acc_base >> crs) : '0;
  wire [17:0] sum      = {2'b00, acc_base - decay} + {samp[16], samp};
  // a negative pair difference wraps rather than flagging
  wire        ovf      = (sum[17:16] == 2'b01);
  wire [15:0] acc_nxt  = sum[15:0];
  wire [7:0]  cnt_nxt  = (cnt_base == CNT_MAX) ? CNT_MAX : cnt_base + 8'h01;
  wire [15:0] fltr_nxt = accum ? (acc_nxt >> crs) : fltr_ff;
  wire [7:0]  cnt_now  = accum ? cnt_nxt : cnt_ff;
  wire        aov_nxt  = aov_ff || (accum && ovf);
  wire [15:0] prev_nxt = ctrl_ff.prev_source_select ? fltr_ff :
                         (ctrl_ff.double_sample_enable ? s1_ff : res_ff);
  wire [15:0] res_nxt  = conv_result;

  // ------------------------------------------------------------
  // error and threshold
  // ------------------------------------------------------------
  wire [15:0] d_rp  = res_nxt - prev_nxt;
  wire [15:0] base  = ctrl_ff.double_sample_enable ? d_rp : res_nxt;
  logic [15:0] err_nxt;

  always_comb begin
    unique case (arc_calc_t'(comp_ff.error_calc_sel))
      CALC_RES_PREV: err_nxt = d_rp;
      CALC_RES_STPT: err_nxt = base - stpt_ff;
      CALC_RES_FLT:  err_nxt = base - fltr_nxt;
      CALC_RSVD:     err_nxt = '0;
      CALC_PREV_FLT: err_nxt = prev_nxt - fltr_nxt;
      CALC_FLT_STPT: err_nxt = fltr_nxt - stpt_ff;
      CALC_RAW:      err_nxt = res_nxt;
      CALC_FLT:      err_nxt = fltr_nxt;
    endcase
  end

  wire signed [15:0] e_s  = signed'(err_nxt);
  wire signed [15:0] lt_s = signed'(lth_ff);
  wire signed [15:0] ut_s = signed'(uth_ff);
  wire above = e_s > ut_s;
  wire below = e_s < lt_s;
  logic hit;

  always_comb begin
    unique case (arc_tmode_t'(comp_ff.threshold_mode_sel))
      TM_NEVER:   hit = 1'b0;
      TM_BELOW:   hit = below;
      TM_AT_ABV:  hit = !below;
      TM_INSIDE:  hit = !below && !above;
      TM_OUTSIDE: hit = below || above;
      TM_AT_BLW:  hit = !above;
      TM_ABOVE:   hit = above;
      TM_ALWAYS:  hit = 1'b1;
    endcase
  end

  // basic and accumulate test every sample, the others wait for the target
  wire thr_en  = (md == MD_BASIC) || (md == MD_ACC) || (cnt_now >= rpt_ff);
  wire tif_set = cyc_done && ((thr_en && hit) || aov_nxt);
  wire tif_new = tif_ff || tif_set;

  // ------------------------------------------------------------
  // go / retrigger
  // ------------------------------------------------------------
  wire sw_go   = wr_ctrl && wctrl.conversion_go;
  wire cnt_aft = cyc_done ? (cnt_now < rpt_ff) : (cnt_ff < rpt_ff);
  wire burst   = (md == MD_BURST) && cnt_aft;
  wire cont    = ctrl_ff.continuous_enable &&
                 !(comp_ff.stop_on_interrupt && tif_new);
  wire burst_clr = (md == MD_BURST) && sw_go;
  arc_ctrl_t nxt_ctrl;

  always_comb begin
    nxt_ctrl = wr_ctrl ? wctrl : ctrl_ff;
    if (sw_go || ext_trigger) begin
      nxt_ctrl.conversion_go = 1'b1;
    end else if (!wr_ctrl && conv_done) begin
      nxt_ctrl.conversion_go = ctrl_ff.conversion_go && (cont || burst);
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ctrl_ff <= '0;
      comp_ff <= '0;
      rpt_ff  <= '0;
      stpt_ff <= '0;
      lth_ff  <= '0;
      uth_ff  <= '0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      if (wr_comp) begin
        comp_ff <= wcomp;
        comp_ff.acc_clear_cmd <= wcomp.acc_clear_cmd || comp_ff.acc_clear_cmd;
      end else if (clr_fire) begin
        comp_ff.acc_clear_cmd <= 1'b0;
      end
      if (wr_rpt) rpt_ff <= hwdata[7:0];
      if (wr_stpt) stpt_ff <= hwdata[15:0];
      if (wr_lth) lth_ff <= hwdata[15:0];
      if (wr_uth) uth_ff <= hwdata[15:0];
    end
  end

  // clear outranks a sample landing in the same cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      acc_ff <= '0;
      cnt_ff <= '0;
      aov_ff <= 1'b0;
    end else if (clr_fire || burst_clr) begin
      acc_ff <= '0;
      cnt_ff <= '0;
      aov_ff <= 1'b0;
    end else if (cyc_done && accum) begin
      acc_ff <= acc_nxt;
      cnt_ff <= cnt_nxt;
      aov_ff <= aov_nxt;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      res_ff  <= '0;
      prev_ff <= '0;
      s1_ff   <= '0;
      fltr_ff <= '0;
      err_ff  <= '0;
      half_ff <= 1'b0;
      uthr_ff <= 1'b0;
      lthr_ff <= 1'b0;
    end else if (conv_done) begin
      half_ff <= first_conv;
      if (first_conv) begin
        s1_ff <= conv_result;
      end else begin
        res_ff  <= res_nxt;
        prev_ff <= prev_nxt;
        fltr_ff <= fltr_nxt;
        err_ff  <= err_nxt;
        uthr_ff <= above;
        lthr_ff <= below;
      end
    end
  end

  // hardware set wins over a write-one clear
  wire clr_math = wr_stat && hwdata[ST_MATH];
  wire clr_tif  = wr_stat && hwdata[ST_TIF];

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      math_ff <= 1'b0;
      tif_ff  <= 1'b0;
    end else begin
      math_ff <= conv_done || (math_ff && !clr_math);
      tif_ff  <= tif_set || (tif_ff && !clr_tif);
    end
  end

  assign conversion_go      = ctrl_ff.conversion_go;
  assign threshold_irq_flag = tif_ff;

  // ------------------------------------------------------------
  // read mux
  // ------------------------------------------------------------
  wire [4:0] stat = {tif_ff, math_ff, lthr_ff, uthr_ff, aov_ff};

  always_comb begin
    unique case (addr_ff)
      A_CTRL:  rd_mux = {27'h0, ctrl_ff};
      A_COMP:  rd_mux = {18'h0, comp_ff};
      A_STAT:  rd_mux = {27'h0, stat};
      A_RPT:   rd_mux = {24'h0, rpt_ff};
      A_CNT:   rd_mux = {24'h0, cnt_ff};
      A_STPT:  rd_mux = {16'h0, stpt_ff};
      A_LTH:   rd_mux = {16'h0, lth_ff};
      A_UTH:   rd_mux = {16'h0, uth_ff};
      A_RES:   rd_mux = {16'h0, res_ff};
      A_PREV:  rd_mux = {16'h0, prev_ff};
      A_ACC:   rd_mux = {16'h0, acc_ff};
      A_FLTR:  rd_mux = {16'h0, fltr_ff};
      A_ERR:   rd_mux = {16'h0, err_ff};
      default: rd_mux = '0;
    endcase
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  wire quiet = !clr_fire && !burst_clr;

  ovf_flag_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && accum && ovf && quiet |=> aov_ff)
    else $error("overflow not flagged");

  cnt_step_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && accum && quiet && !restart && cnt_ff != CNT_MAX
    |=> cnt_ff == $past(cnt_ff) + 8'h01)
    else $error("sample count did not step");

  clr_done_a: assert property (@(posedge ref_clk) disable iff (rst)
    clr_fire && !wr_comp |=> acc_ff == '0 && cnt_ff == '0 && !aov_ff
    && !comp_ff.acc_clear_cmd)
    else $error("clear left state behind");

  clr_rc_a: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_ff.clock_src_rc && clr_st_ff == CLR_IDLE |-> !clr_fire)
    else $error("rc clear finished early");

  basic_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && md == MD_BASIC && quiet |=> $stable(acc_ff) && $stable(cnt_ff))
    else $error("basic mode touched accumulator");

  fltr_shift_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && md == MD_ACC && quiet |=> fltr_ff == (acc_ff >> $past(crs)))
    else $error("filtered value not shifted sum");

  avg_wait_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && md == MD_AVG && cnt_now < rpt_ff && !aov_nxt && !tif_ff
    |=> !tif_ff)
    else $error("average tested before target");

  ds_first_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done && first_conv |=> $stable(err_ff) ##0 math_ff)
    else $error("error computed on first of pair");

  tif_always_a: assert property (@(posedge ref_clk) disable iff (rst)
    cyc_done && thr_en && comp_ff.threshold_mode_sel == TM_ALWAYS |=> tif_ff [*1] ##0 uthr_ff == $past(above))
    else $error("always mode did not interrupt");

  cont_go_a: assert property (@(posedge ref_clk) disable iff (rst)
    conv_done && ctrl_ff.conversion_go && ctrl_ff.continuous_enable
    && !comp_ff.stop_on_interrupt && !wr_ctrl |=> conversion_go)
    else $error("continuous mode did not retrigger");

endmodule : arc_unit

`default_nettype wire

// *** sim/arc_conv_model.sv ***
// converter core stand-in: answers a raised conversion_go with one conv_done
// assumes the bench sets smp and dly before go rises; delay 0 answers promptly
`default_nettype none

module arc_conv_model (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        conversion_go,
  input  wire logic [15:0] smp,
  input  wire logic [3:0]  dly,
  output logic             conv_done,
  output logic [15:0]      conv_result,
  output int               n_conv
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    conv_done = 1'b0;
    conv_result = 16'h0000;
    n_conv = 0;
    forever begin
      // sampled mid-cycle so the go level seen is the settled one
      @(negedge ref_clk);
      if (!rst && conversion_go) begin
        repeat (dly + 4'h1) @(posedge ref_clk);
        conv_done <= 1'b1;
        conv_result <= smp;
        n_conv <= n_conv + 1;
        @(posedge ref_clk);
        conv_done <= 1'b0;
        // result is only valid with the strobe: show the inverse after it
        conv_result <= ~smp;
      end
    end
  end
endmodule : arc_conv_model

`default_nettype wire

// *** sim/testbench.sv ***
// self-checking bench for arc_unit: ahb-lite master tasks, converter stand-in,
// integer model of accumulator, error and threshold logic
// assumes one design instance and hready looped from hreadyout
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import arc_pkg::*;

  logic        ref_clk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  logic        ext_trigger = 1'b0, rc_tick = 1'b0;
  logic        hreadyout, hresp, conv_done, conversion_go, threshold_irq_flag;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2, rcn = 3'h0;
  logic [15:0] conv_result, smp = 16'h0;
  logic [3:0]  dly = 4'h0;
  logic        ovf = 1'b0, hi, lo, irq;
  int          n_conv, error_cnt = 0, comparisons = 0, n0;
  int          acc = 0, cnt = 0, res = 0, prev = 0, flt = 0, e = 0, comp = 0;
  int          md, sh, cl, tm, rpt = 3, stp = 80, lt = -100, ut = 100;
  int          cw = 0, s1 = 0, half = 0;

  arc_unit dut (.ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .conv_done(conv_done), .conv_result(conv_result), .ext_trigger(ext_trigger),
    .rc_tick(rc_tick), .conversion_go(conversion_go),
    .threshold_irq_flag(threshold_irq_flag));

  arc_conv_model conv_core (.ref_clk(ref_clk), .rst(rst), .conversion_go(conversion_go),
    .smp(smp), .dly(dly), .conv_done(conv_done), .conv_result(conv_result),
    .n_conv(n_conv));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // rc oscillator enable, one pulse every eight system cycles
  always @(posedge ref_clk) begin
    rcn <= rcn + 3'h1;
    rc_tick <= (rcn == 3'h7);
  end

  task automatic test_done();
    $display("errors %0d in %0d comparisons", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic lim(input int n, input int top);
    if (n >= top) begin
      error_cnt++;
      $display("wrong value at %0t: wait ran out", $time);
      test_done();
    end
  endtask : lim

  // one bus phase: ends at the edge where hready is sampled high
  task automatic bwait(output logic [31:0] d);
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 40);
    d = hrdata;
    lim(n, 40);
    @(posedge ref_clk);
  endtask : bwait

  task automatic bus(input logic w, input logic [7:0] a, input int wd);
    logic [31:0] d;
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    bwait(d);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= 32'(wd);
    bwait(rd);
  endtask : bus

  task automatic rchk(input logic [7:0] a, input int x, input logic [31:0] m = 32'hFFFFFFFF);
    bus(1'b0, a, 0);
    chk(rd & m, 32'(x) & m);
  endtask : rchk

  task automatic cfg(input int m, input int s, input int c, input int t, input int soi);
    md = m;
    sh = s;
    cl = c;
    tm = t;
    comp = m | s << 3 | c << 7 | t << 10 | soi << 13;
    bus(1'b1, A_COMP, comp);
  endtask : cfg

  task automatic model(input int s);
    logic [7:0] hv;
    int         es, b;
    if ((cw & 8) != 0 && half == 0) begin
      // first of a pair: only held, no cycle completes
      s1 = s;
      half = 1;
      irq = 1'b0;
      return;
    end
    half = 0;
    prev = ((cw & 16) != 0) ? flt : (((cw & 8) != 0) ? s1 : res);
    res = s;
    b = ((cw & 8) != 0) ? res - prev : res;
    if ((md == 2 || md == 3) && cnt >= rpt) begin
      acc = 0;
      cnt = 0;
    end
    if (md == 4) acc = acc - (acc >> sh);
    if (md != 0) begin
      acc = acc + (((cw & 8) != 0) ? s - s1 : s);
      if (acc > 65535) ovf = 1'b1;
      acc = acc & 65535;
      if (cnt < 255) cnt++;
      flt = acc >> sh;
    end
    case (cl)
      0: e = res - prev;
      1: e = b - stp;
      2: e = b - flt;
      3: e = 0;
      4: e = prev - flt;
      5: e = flt - stp;
      6: e = res;
      default: e = flt;
    endcase
    e = e & 65535;
    es = (e > 32767) ? e - 65536 : e;
    hi = es > ut;
    lo = es < lt;
    hv = {1'b1, hi, !hi, lo | hi, !lo & !hi, !lo, lo, 1'b0};
    irq = ovf | ((md < 2 || cnt >= rpt) & hv[tm]);
  endtask : model

  // one conversion, started by go write or external trigger, then all checked
  task automatic conv(input int s);
    int n;
    smp <= 16'(s);
    dly <= 4'($urandom_range(0, 5));
    bus(1'b1, A_STAT, 'h18);
    n0 = n_conv;
    if (s % 2 == 1) begin
      ext_trigger <= 1'b1;
      @(posedge ref_clk);
      ext_trigger <= 1'b0;
    end
    else bus(1'b1, A_CTRL, cw | 1);
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (n_conv == n0 && n < 60);
    lim(n, 60);
    @(posedge ref_clk);
    model(s);
    rchk(A_RES, res);
    rchk(A_PREV, prev);
    rchk(A_ACC, acc);
    rchk(A_CNT, cnt);
    rchk(A_FLTR, flt);
    rchk(A_ERR, e, 32'h0000FFFF);
    rchk(A_STAT, {27'h0, irq, 1'b1, lo, hi, ovf}, 32'h1F);
    chk(32'(threshold_irq_flag), 32'(irq));
  endtask : conv

  task automatic go_low();
    int n;
    n = 0;
    do begin
      @(negedge ref_clk);
      n++;
    end while (conversion_go !== 1'b0 && n < 400);
    lim(n, 400);
    @(posedge ref_clk);
  endtask : go_low

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    void'($urandom(8));
    repeat (12) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    for (int a = 0; a < 'h40; a += 4) rchk(8'(a), 0);
    bus(1'b1, 8'h3C, 'hFFFF);
    bus(1'b1, A_ACC, 'h1234);
    rchk(8'h3C, 0);
    rchk(A_ACC, 0);
    bus(1'b1, A_STPT, stp);
    bus(1'b1, A_LTH, lt);
    bus(1'b1, A_UTH, ut);
    bus(1'b1, A_RPT, rpt);
    for (int t = 0; t < 8; t++) begin
      cfg(0, 0, 0, t, 0);
      repeat (5) conv($urandom_range(0, 400));
    end
    for (int c = 0; c < 8; c++) begin
      cfg(1, 1, c, 7, 0);
      repeat (3) conv($urandom_range(0, 600));
    end
    cfg(1, 0, 6, 0, 0);
    conv('hF000);
    conv('hF001);
    bus(1'b1, A_COMP, comp | 'h40);
    acc = 0;
    cnt = 0;
    ovf = 1'b0;
    rchk(A_COMP, comp);
    rchk(A_ACC, 0);
    rchk(A_CNT, 0);
    rchk(A_STAT, 0, 32'h1);
    cfg(2, 1, 6, 7, 0);
    repeat (5) conv($urandom_range(0, 900));
    cfg(4, 2, 7, 0, 0);
    repeat (6) conv($urandom_range(0, 4000));
    bus(1'b1, A_CTRL, 'h4);
    bus(1'b1, A_COMP, comp | 'h40);
    rchk(A_COMP, comp | 'h40);
    repeat (60) @(posedge ref_clk);
    rchk(A_COMP, comp);
    rchk(A_ACC, 0);
    acc = 0;
    cnt = 0;
    // double sampling in pairs, last pass takes previous from the filter
    for (int c = 0; c < 3; c++) begin
      cw = (c == 2) ? 'h18 : 'h8;
      bus(1'b1, A_CTRL, cw);
      cfg(1, 0, c, 7, 0);
      repeat (4) conv($urandom_range(0, 600));
    end
    cw = 0;
    cfg(3, 2, 7, 7, 0);
    smp <= 16'h0100;
    bus(1'b1, A_STAT, 'h18);
    n0 = n_conv;
    bus(1'b1, A_CTRL, 1);
    go_low();
    chk(32'(n_conv - n0), 32'(rpt));
    rchk(A_CNT, rpt);
    rchk(A_FLTR, (rpt * 256) >> 2);
    chk(32'(threshold_irq_flag), 32'h1);
    cfg(0, 0, 7, 7, 1);
    bus(1'b1, A_STAT, 'h18);
    n0 = n_conv;
    bus(1'b1, A_CTRL, 3);
    go_low();
    chk(32'(n_conv - n0), 32'h1);
    cfg(0, 0, 7, 0, 0);
    n0 = n_conv;
    bus(1'b1, A_CTRL, 3);
    repeat (60) @(posedge ref_clk);
    bus(1'b1, A_CTRL, 0);
    go_low();
    chk(32'(n_conv - n0 > 2), 32'h1);
    test_done();
  end
endmodule : testbench

`default_nettype wire
